// ### design/scct_pkg.sv
// Shared constants and types for the slow clock counter and periodic ticker
package scct_pkg;

  // ==========================================================================
  // Register indices (Avalon word address = index, byte address = 4 * index)
  localparam logic [4:0] SCCT_IDX_CTRL     = 5'h00;
  localparam logic [4:0] SCCT_IDX_STATUS   = 5'h01;
  localparam logic [4:0] SCCT_IDX_IRQEN    = 5'h02;
  localparam logic [4:0] SCCT_IDX_IRQFLAG  = 5'h03;
  localparam logic [4:0] SCCT_IDX_DEBUG    = 5'h05;
  localparam logic [4:0] SCCT_IDX_TRIM     = 5'h06;
  localparam logic [4:0] SCCT_IDX_SRCSEL   = 5'h07;
  localparam logic [4:0] SCCT_IDX_COUNT    = 5'h08;
  localparam logic [4:0] SCCT_IDX_WRAP     = 5'h0A;
  localparam logic [4:0] SCCT_IDX_MATCH    = 5'h0C;
  localparam logic [4:0] SCCT_IDX_TCTRL    = 5'h10;
  localparam logic [4:0] SCCT_IDX_TSTATUS  = 5'h11;
  localparam logic [4:0] SCCT_IDX_TIRQEN   = 5'h12;
  localparam logic [4:0] SCCT_IDX_TIRQFLAG = 5'h13;
  localparam logic [4:0] SCCT_IDX_TDEBUG   = 5'h15;

  // ==========================================================================
  // Field positions
  localparam int unsigned SCCT_BIT_WRAP      = 0;
  localparam int unsigned SCCT_BIT_MATCH     = 1;
  localparam int unsigned SCCT_BIT_TICK      = 0;
  localparam int unsigned SCCT_BIT_DBG       = 0;
  localparam int unsigned SCCT_BUSY_CTRL     = 0;
  localparam int unsigned SCCT_BUSY_COUNT    = 1;
  localparam int unsigned SCCT_BUSY_WRAP     = 2;
  localparam int unsigned SCCT_BUSY_MATCH    = 3;
  localparam int unsigned SCCT_BUSY_TCTRL    = 4;
  localparam int unsigned SCCT_NUM_BUSY      = 5;
  localparam int unsigned SCCT_TAP_LOW_BIT   = 5;
  localparam int unsigned SCCT_TAP_COUNT     = 8;

  // ==========================================================================
  // Reset values and timing
  localparam logic [7:0]  SCCT_RST_BYTE     = 8'h00;
  localparam logic [15:0] SCCT_RST_COUNT    = 16'h0000;
  localparam logic [15:0] SCCT_RST_WRAP     = 16'hFFFF;
  localparam logic [15:0] SCCT_RST_MATCH    = 16'h0000;
  localparam logic [1:0]  SCCT_SYNC_TICKS   = 2'h2;
  localparam logic [19:0] SCCT_CORR_SPAN    = 20'hF4240;
  localparam logic [3:0]  SCCT_PERIOD_OFF   = 4'h0;
  localparam logic [3:0]  SCCT_PERIOD_RSV   = 4'hF;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic       keep;
    logic [3:0] presc;
    logic       corr;
    logic       rsv;
    logic       en;
  } scct_ctrl_type;

  typedef struct packed {
    logic       rsv7;
    logic [3:0] period;
    logic [1:0] rsv;
    logic       en;
  } scct_tctrl_type;

  typedef struct packed {
    logic       sign;
    logic [6:0] mag;
  } scct_trim_type;

endpackage

// ### design/scct_prescaler.sv
// Shared 15-bit prescaler with evenly spread crystal error correction
`timescale 1ns/1ns
module scct_prescaler (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_slow_tick,
  input  wire logic                  i_run,
  input  wire logic                  i_corr_en,
  input  wire scct_pkg::scct_trim_type i_trim,
  input  wire logic [3:0]            i_presc,
  output logic      [14:0]           o_psc_q,
  output logic                       o_div_tick_q
);

  logic [19:0] acc_q;
  logic        pend_q;
  logic [1:0]  step;
  logic [14:0] psc_d;
  logic [20:0] acc_sum;

  // True when advancing from a to b crosses a multiple of 2**p; a wrap of the
  // 15-bit count crosses every multiple, so division by 32768 still ticks
  function automatic logic crosses(input logic [14:0] a, input logic [14:0] b,
                                   input logic [3:0] p);
    logic [15:0] ua;
    logic [15:0] ub;
    ua = {1'b0, a} >> p;
    ub = {1'b0, b} >> p;
    crosses = (ua != ub) | (b < a);
  endfunction

  // A correction cycle either holds the count (extra cycle) or skips one
  always_comb begin
    step = 2'h1;
    if (pend_q) begin
      step = i_trim.sign ? 2'h2 : 2'h0;
    end
    psc_d   = o_psc_q + {13'h0000, step};
    acc_sum = {1'b0, acc_q} + {14'h0000, i_trim.mag};
  end

  // ==========================================================================
  // Prescaler counter, stopped while both functions are off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_psc_q      <= 15'h0000;
      o_div_tick_q <= 1'b0;
    end else begin
      o_div_tick_q <= 1'b0;
      if (i_slow_tick && i_run) begin
        o_psc_q      <= psc_d;
        o_div_tick_q <= crosses(o_psc_q, psc_d, i_presc);
      end
    end
  end

  // ==========================================================================
  // Correction accumulator; a pending cycle still completes after disable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q  <= 20'h00000;
      pend_q <= 1'b0;
    end else if (i_slow_tick && i_run) begin
      if (pend_q) begin
        pend_q <= 1'b0;
      end
      if (i_corr_en) begin
        if (acc_sum >= {1'b0, scct_pkg::SCCT_CORR_SPAN}) begin
          acc_q  <= 20'(acc_sum - {1'b0, scct_pkg::SCCT_CORR_SPAN});
          pend_q <= 1'b1;
        end else begin
          acc_q <= acc_sum[19:0];
        end
      end
    end
  end

endmodule

// ### design/scct_top.sv
// Slow clock counter and periodic ticker with Avalon-MM register access
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns

module scct_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_slow_clk,
  input  wire logic        i_cpu_halted,
  input  wire logic        i_sleep_standby,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [1:0]       o_source_select_q,
  output logic             o_counter_irq_q,
  output logic             o_ticker_irq_q,
  output logic             o_wrap_event_q,
  output logic             o_match_event_q,
  output logic             o_ticker_out_q,
  output logic [7:0]       o_tap_events_q
);

  // ==========================================================================
  // Slow clock pin synchroniser and edge detector
  logic slow_s1_q;
  logic slow_s2_q;
  logic slow_s3_q;
  logic slow_tick;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end else begin
      slow_s1_q <= i_slow_clk;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  assign slow_tick = slow_s2_q & ~slow_s3_q;

  // ==========================================================================
  // Software-visible registers and their active copies
  scct_pkg::scct_ctrl_type  ctrl_q;
  scct_pkg::scct_ctrl_type  ctrl_act_q;
  scct_pkg::scct_tctrl_type tctrl_q;
  scct_pkg::scct_tctrl_type tctrl_act_q;
  scct_pkg::scct_trim_type  trim_q;
  logic [15:0] count_q;
  logic [15:0] count_wr_q;
  logic [15:0] wrap_q;
  logic [15:0] wrap_act_q;
  logic [15:0] match_q;
  logic [15:0] match_act_q;
  logic [1:0]  irq_en_q;
  logic [1:0]  irq_flag_q;
  logic        tirq_en_q;
  logic        tirq_flag_q;
  logic        cnt_dbg_q;
  logic        tick_dbg_q;
  logic [1:0]  busy_q [scct_pkg::SCCT_NUM_BUSY];
  logic [scct_pkg::SCCT_NUM_BUSY-1:0] busy;
  logic [scct_pkg::SCCT_NUM_BUSY-1:0] apply;
  logic [scct_pkg::SCCT_NUM_BUSY-1:0] wr_hit;

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the access completes
  logic wr_take;
  logic rd_prep;

  assign wr_take = i_avs_write & ~o_avs_waitrequest;
  assign rd_prep = i_avs_read & o_avs_waitrequest;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end

  // Byte-lane merge used by the 16-bit COUNT, WRAP and MATCH registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wdata,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wdata[15:8] : old_v[15:8], be[0] ? wdata[7:0] : old_v[7:0]};
  endfunction

  function automatic logic wr_at(input logic [4:0] idx);
    wr_at = wr_take & (i_avs_address == idx) & i_avs_byteenable[0];
  endfunction

  assign wr_hit[scct_pkg::SCCT_BUSY_CTRL]  = wr_at(scct_pkg::SCCT_IDX_CTRL);
  assign wr_hit[scct_pkg::SCCT_BUSY_COUNT] = wr_take & (i_avs_address == scct_pkg::SCCT_IDX_COUNT)
                                             & (|i_avs_byteenable[1:0]);
  assign wr_hit[scct_pkg::SCCT_BUSY_WRAP]  = wr_take & (i_avs_address == scct_pkg::SCCT_IDX_WRAP)
                                             & (|i_avs_byteenable[1:0]);
  assign wr_hit[scct_pkg::SCCT_BUSY_MATCH] = wr_take & (i_avs_address == scct_pkg::SCCT_IDX_MATCH)
                                             & (|i_avs_byteenable[1:0]);
  assign wr_hit[scct_pkg::SCCT_BUSY_TCTRL] = wr_at(scct_pkg::SCCT_IDX_TCTRL);

  // ==========================================================================
  // Plain writable registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q            <= scct_pkg::scct_ctrl_type'(scct_pkg::SCCT_RST_BYTE);
      tctrl_q           <= scct_pkg::scct_tctrl_type'(scct_pkg::SCCT_RST_BYTE);
      trim_q            <= scct_pkg::scct_trim_type'(scct_pkg::SCCT_RST_BYTE);
      count_wr_q        <= scct_pkg::SCCT_RST_COUNT;
      wrap_q            <= scct_pkg::SCCT_RST_WRAP;
      match_q           <= scct_pkg::SCCT_RST_MATCH;
      irq_en_q          <= 2'h0;
      tirq_en_q         <= 1'b0;
      cnt_dbg_q         <= 1'b0;
      tick_dbg_q        <= 1'b0;
      o_source_select_q <= 2'h0;
    end else begin
      if (wr_hit[scct_pkg::SCCT_BUSY_CTRL]) begin
        ctrl_q     <= scct_pkg::scct_ctrl_type'(i_avs_writedata[7:0]);
        ctrl_q.rsv <= 1'b0;
      end
      if (wr_hit[scct_pkg::SCCT_BUSY_TCTRL]) begin
        tctrl_q        <= scct_pkg::scct_tctrl_type'(i_avs_writedata[7:0]);
        tctrl_q.rsv7   <= 1'b0;
        tctrl_q.rsv    <= 2'h0;
      end
      if (wr_hit[scct_pkg::SCCT_BUSY_COUNT]) begin
        count_wr_q <= merge16(count_q, i_avs_writedata, i_avs_byteenable);
      end
      if (wr_hit[scct_pkg::SCCT_BUSY_WRAP]) begin
        wrap_q <= merge16(wrap_q, i_avs_writedata, i_avs_byteenable);
      end
      if (wr_hit[scct_pkg::SCCT_BUSY_MATCH]) begin
        match_q <= merge16(match_q, i_avs_writedata, i_avs_byteenable);
      end
      if (wr_at(scct_pkg::SCCT_IDX_TRIM)) begin
        trim_q <= scct_pkg::scct_trim_type'(i_avs_writedata[7:0]);
      end
      if (wr_at(scct_pkg::SCCT_IDX_IRQEN)) begin
        irq_en_q <= i_avs_writedata[1:0];
      end
      if (wr_at(scct_pkg::SCCT_IDX_TIRQEN)) begin
        tirq_en_q <= i_avs_writedata[scct_pkg::SCCT_BIT_TICK];
      end
      if (wr_at(scct_pkg::SCCT_IDX_DEBUG)) begin
        cnt_dbg_q <= i_avs_writedata[scct_pkg::SCCT_BIT_DBG];
      end
      if (wr_at(scct_pkg::SCCT_IDX_TDEBUG)) begin
        tick_dbg_q <= i_avs_writedata[scct_pkg::SCCT_BIT_DBG];
      end
      if (wr_at(scct_pkg::SCCT_IDX_SRCSEL)) begin
        o_source_select_q <= i_avs_writedata[1:0];
      end
    end
  end

  // ==========================================================================
  // Slow-domain synchronisation: each CTRL, COUNT, WRAP, MATCH or TCTRL write lands two slow cycles later
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < scct_pkg::SCCT_NUM_BUSY; i++) begin
        busy_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < scct_pkg::SCCT_NUM_BUSY; i++) begin
        if (wr_hit[i]) begin
          busy_q[i] <= scct_pkg::SCCT_SYNC_TICKS;
        end else if (slow_tick && busy[i]) begin
          busy_q[i] <= busy_q[i] - 2'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < scct_pkg::SCCT_NUM_BUSY; i++) begin
      busy[i]  = (busy_q[i] != 2'h0);
      apply[i] = slow_tick & (busy_q[i] == 2'h1) & ~wr_hit[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_act_q  <= scct_pkg::scct_ctrl_type'(scct_pkg::SCCT_RST_BYTE);
      tctrl_act_q <= scct_pkg::scct_tctrl_type'(scct_pkg::SCCT_RST_BYTE);
      wrap_act_q  <= scct_pkg::SCCT_RST_WRAP;
      match_act_q <= scct_pkg::SCCT_RST_MATCH;
    end else begin
      if (apply[scct_pkg::SCCT_BUSY_CTRL]) begin
        ctrl_act_q <= ctrl_q;
      end
      if (apply[scct_pkg::SCCT_BUSY_TCTRL]) begin
        tctrl_act_q <= tctrl_q;
      end
      if (apply[scct_pkg::SCCT_BUSY_WRAP]) begin
        wrap_act_q <= wrap_q;
      end
      if (apply[scct_pkg::SCCT_BUSY_MATCH]) begin
        match_act_q <= match_q;
      end
    end
  end

  // ==========================================================================
  // Shared prescaler; its phase is kept across enables
  logic [14:0] psc;
  logic        div_tick;
  logic        psc_run;

  assign psc_run = ctrl_act_q.en | tctrl_act_q.en;

  scct_prescaler u_prescaler (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_slow_tick  (slow_tick),
    .i_run        (psc_run),
    .i_corr_en    (ctrl_act_q.corr),
    .i_trim       (trim_q),
    .i_presc      (ctrl_act_q.presc),
    .o_psc_q      (psc),
    .o_div_tick_q (div_tick)
  );

  // ==========================================================================
  // Counter with wrap and match
  logic cnt_run;
  logic cnt_step;
  logic hit_wrap;
  logic hit_match;

  assign cnt_run   = ctrl_act_q.en & ~(i_cpu_halted & ~cnt_dbg_q)
                     & ~(i_sleep_standby & ~ctrl_act_q.keep);
  assign cnt_step  = div_tick & cnt_run;
  assign hit_wrap  = cnt_step & (count_q == wrap_act_q);
  assign hit_match = cnt_step & (count_q == match_act_q);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= scct_pkg::SCCT_RST_COUNT;
    end else if (apply[scct_pkg::SCCT_BUSY_COUNT]) begin
      count_q <= count_wr_q;
    end else if (hit_wrap) begin
      count_q <= 16'h0000;
    end else if (cnt_step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Pulses are stretched to one slow period, cleared by the next slow edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wrap_event_q  <= 1'b0;
      o_match_event_q <= 1'b0;
    end else begin
      if (hit_wrap) begin
        o_wrap_event_q <= 1'b1;
      end else if (slow_tick) begin
        o_wrap_event_q <= 1'b0;
      end
      if (hit_match) begin
        o_match_event_q <= 1'b1;
      end else if (slow_tick) begin
        o_match_event_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Ticker output and level taps
  logic tick_level;
  logic tick_rise;

  always_comb begin
    tick_level = 1'b0;
    if (tctrl_act_q.en && tctrl_act_q.period != scct_pkg::SCCT_PERIOD_OFF
        && tctrl_act_q.period != scct_pkg::SCCT_PERIOD_RSV) begin
      tick_level = psc[tctrl_act_q.period];
    end
    if (i_cpu_halted && !tick_dbg_q) begin
      tick_level = 1'b0;
    end
  end

  assign tick_rise = tick_level & ~o_ticker_out_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ticker_out_q <= 1'b0;
      o_tap_events_q <= 8'h00;
    end else begin
      o_ticker_out_q <= tick_level;
      o_tap_events_q <= psc_run ? psc[scct_pkg::SCCT_TAP_LOW_BIT +: scct_pkg::SCCT_TAP_COUNT]
                                : 8'h00;
    end
  end

  // ==========================================================================
  // Interrupt flags: a set in the same cycle as a clear wins
  logic [1:0] flag_clr;
  logic       tflag_clr;

  assign flag_clr  = wr_at(scct_pkg::SCCT_IDX_IRQFLAG) ? i_avs_writedata[1:0] : 2'h0;
  assign tflag_clr = wr_at(scct_pkg::SCCT_IDX_TIRQFLAG)
                     & i_avs_writedata[scct_pkg::SCCT_BIT_TICK];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_flag_q      <= 2'h0;
      tirq_flag_q     <= 1'b0;
      o_counter_irq_q <= 1'b0;
      o_ticker_irq_q  <= 1'b0;
    end else begin
      irq_flag_q  <= (irq_flag_q & ~flag_clr) | {hit_match, hit_wrap};
      tirq_flag_q <= (tirq_flag_q & ~tflag_clr) | tick_rise;
      o_counter_irq_q <= |(irq_flag_q & irq_en_q);
      o_ticker_irq_q  <= tirq_flag_q & tirq_en_q;
    end
  end

  // ==========================================================================
  // Read data, prepared in the wait cycle; unmapped words read zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd_prep) begin
      unique case (i_avs_address)
        scct_pkg::SCCT_IDX_CTRL:     o_avs_readdata <= {24'h000000, ctrl_q};
        scct_pkg::SCCT_IDX_STATUS:   o_avs_readdata <= {28'h0000000, busy[3:0]};
        scct_pkg::SCCT_IDX_IRQEN:    o_avs_readdata <= {30'h00000000, irq_en_q};
        scct_pkg::SCCT_IDX_IRQFLAG:  o_avs_readdata <= {30'h00000000, irq_flag_q};
        scct_pkg::SCCT_IDX_DEBUG:    o_avs_readdata <= {31'h00000000, cnt_dbg_q};
        scct_pkg::SCCT_IDX_TRIM:     o_avs_readdata <= {24'h000000, trim_q};
        scct_pkg::SCCT_IDX_SRCSEL:   o_avs_readdata <= {30'h00000000, o_source_select_q};
        scct_pkg::SCCT_IDX_COUNT:    o_avs_readdata <= {16'h0000, count_q};
        scct_pkg::SCCT_IDX_WRAP:     o_avs_readdata <= {16'h0000, wrap_q};
        scct_pkg::SCCT_IDX_MATCH:    o_avs_readdata <= {16'h0000, match_q};
        scct_pkg::SCCT_IDX_TCTRL:    o_avs_readdata <= {24'h000000, tctrl_q};
        scct_pkg::SCCT_IDX_TSTATUS:  o_avs_readdata <= {31'h00000000, busy[4]};
        scct_pkg::SCCT_IDX_TIRQEN:   o_avs_readdata <= {31'h00000000, tirq_en_q};
        scct_pkg::SCCT_IDX_TIRQFLAG: o_avs_readdata <= {31'h00000000, tirq_flag_q};
        scct_pkg::SCCT_IDX_TDEBUG:   o_avs_readdata <= {31'h00000000, tick_dbg_q};
        default:                     o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ### tb/scct_top_asserts.sv
// Port-level checker for the slow clock counter and periodic ticker
`timescale 1ns/1ns
module scct_top_asserts (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_cpu_halted,
  input  wire logic       i_avs_write,
  input  wire logic       o_avs_waitrequest,
  input  wire logic       o_counter_irq_q,
  input  wire logic       o_ticker_irq_q,
  input  wire logic       o_wrap_event_q,
  input  wire logic       o_match_event_q,
  input  wire logic       o_ticker_out_q,
  input  wire logic [7:0] o_tap_events_q
);
  logic wr_done;
  assign wr_done = i_avs_write & ~o_avs_waitrequest;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================================
  // Event pulses, sized for a slow clock of eight bus cycles
  sequence hold_s(logic s);
    s[*4] ##[1:6] !s;
  endsequence
  wrap_pulse_a: assert property ($rose(o_wrap_event_q) |-> hold_s(o_wrap_event_q))
    else $error("wrap event pulse length wrong");
  match_pulse_a: assert property ($rose(o_match_event_q) |-> hold_s(o_match_event_q))
    else $error("match event pulse length wrong");
  // ==========================================================================
  // Requests follow a flag or an enable; only a register write drops them
  cnt_irq_rise_a: assert property ($rose(o_counter_irq_q) |->
    $past(o_wrap_event_q | o_match_event_q) || $past(wr_done, 2))
    else $error("counter request rose without cause");
  cnt_irq_fall_a: assert property ($fell(o_counter_irq_q) |-> $past(wr_done, 2))
    else $error("counter request dropped without a write");
  tick_irq_rise_a: assert property ($rose(o_ticker_irq_q) |->
    o_ticker_out_q || $past(wr_done, 2))
    else $error("ticker request rose without an output edge");
  tick_irq_fall_a: assert property ($fell(o_ticker_irq_q) |-> $past(wr_done, 2))
    else $error("ticker request dropped without a write");
  tick_half_a: assert property ($rose(o_ticker_out_q) |=>
    (o_ticker_out_q || i_cpu_halted)[*8])
    else $error("ticker high phase too short");
  tap_ripple_a: assert property ($changed(o_tap_events_q[7:1]) |->
    $fell(o_tap_events_q[0]) || o_tap_events_q == 8'h00 || $past(o_tap_events_q) == 8'h00)
    else $error("upper tap moved without lower tap falling");
  tap_hold_a: assert property ($changed(o_tap_events_q[0]) |=>
    $stable(o_tap_events_q[0])[*8])
    else $error("divide by 64 tap changes too fast");
endmodule
bind scct_top scct_top_asserts u_chk (.*);

// ### tb/tb.sv
// Self-checking bench for the slow clock counter and periodic ticker
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  logic        i_clk, i_rst_b, i_slow_clk, i_cpu_halted, i_sleep_standby;
  logic        i_avs_read, i_avs_write, o_avs_waitrequest, ok;
  logic [4:0]  i_avs_address;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd_q, c_q;
  logic [1:0]  o_source_select_q;
  logic        o_counter_irq_q, o_ticker_irq_q, o_wrap_event_q, o_match_event_q;
  logic        o_ticker_out_q;
  logic [7:0]  o_tap_events_q;
  int          fail_count, n_tests, w, m, s;
  time         t0;
  scct_top u_dut (.*);
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Offset start keeps slow edges away from bus edges; period is exact
  initial begin
    i_slow_clk = 1'b0;
    #7;
    forever #80 i_slow_clk = ~i_slow_clk;
  end
  // ==========================================================================
  // Bus access: hold until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    rd_q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic sync;
    do acc(1'b0, 5'h01, '0); while (rd_q[3:0] !== 4'h0);
    do acc(1'b0, 5'h11, '0); while (rd_q[0] !== 1'b0);
  endtask
  // Count is held when two reads four slow cycles apart agree
  task automatic still(output logic held);
    acc(1'b0, 5'h08, '0);
    c_q = rd_q;
    repeat (4) @(posedge i_slow_clk);
    acc(1'b0, 5'h08, '0);
    held = (rd_q === c_q);
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    test_done;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h279272BC));
    {i_rst_b, i_cpu_halted, i_sleep_standby, i_avs_read, i_avs_write} = '0;
    {i_avs_address, i_avs_writedata} = '0;
    i_avs_byteenable = 4'hF;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    s = $urandom_range(3, 0);
    acc(1'b1, 5'h07, 32'(s));
    acc(1'b0, 5'h0A, '0);
    `CHK(rd_q[15:0], scct_pkg::SCCT_RST_WRAP)
    `CHK(o_source_select_q, 2'(s))
    w = $urandom_range(6, 3);
    m = $urandom_range(w - 1, 1);
    acc(1'b1, 5'h0A, 32'(w));
    acc(1'b0, 5'h01, '0);
    `CHK(rd_q[2], 1'b1)
    acc(1'b1, 5'h0C, 32'(m));
    acc(1'b1, 5'h02, 32'h3);
    sync;
    // Ticker alone, period measured between rising edges
    for (int p = 1; p <= 3; p++) begin
      acc(1'b1, 5'h10, 32'((p << 3) | 1));
      sync;
      @(posedge o_ticker_out_q);
      t0 = $time;
      @(posedge o_ticker_out_q);
      `CHK(($time - t0) / 160, 2 << p)
    end
    acc(1'b0, 5'h13, '0);
    `CHK(rd_q[0], 1'b1)
    acc(1'b1, 5'h12, 32'h1);
    repeat (2) @(negedge i_clk);
    `CHK(o_ticker_irq_q, 1'b1)
    acc(1'b1, 5'h13, 32'h1);
    acc(1'b0, 5'h13, '0);
    `CHK(rd_q[0], 1'b0)
    // Counter wrap spacing at the two lowest prescale settings
    // Negative trim is only switched on together with a prescale of two
    acc(1'b1, 5'h06, 32'h80 | 32'($urandom_range(127, 1)));
    for (int p = 0; p <= 1; p++) begin
      acc(1'b1, 5'h00, 32'((p << 3) | (p << 2) | 1));
      sync;
      @(posedge o_wrap_event_q);
      t0 = $time;
      @(posedge o_wrap_event_q);
      `CHK(($time - t0) / 160, (w + 1) << p)
    end
    acc(1'b1, 5'h03, '0);
    acc(1'b0, 5'h03, '0);
    `CHK(rd_q[0], 1'b1)
    `CHK(o_counter_irq_q, 1'b1)
    acc(1'b1, 5'h03, 32'h3);
    acc(1'b0, 5'h03, '0);
    `CHK(rd_q[0], 1'b0)
    @(posedge o_match_event_q);
    acc(1'b0, 5'h08, '0);
    `CHK(rd_q[15:0], 16'(m + 1))
    `CHK(o_match_event_q, 1'b1)
    // Debug halt, standby sleep and stop
    i_cpu_halted <= 1'b1;
    still(ok);
    `CHK(ok, 1'b1)
    `CHK(o_ticker_out_q, 1'b0)
    acc(1'b1, 5'h05, 32'h1);
    still(ok);
    `CHK(ok, 1'b0)
    i_cpu_halted <= 1'b0;
    i_sleep_standby <= 1'b1;
    still(ok);
    `CHK(ok, 1'b1)
    acc(1'b1, 5'h00, 32'h89);
    sync;
    still(ok);
    `CHK(ok, 1'b0)
    i_sleep_standby <= 1'b0;
    acc(1'b1, 5'h00, '0);
    sync;
    still(ok);
    `CHK(ok, 1'b1)
    @(posedge o_tap_events_q[0]);
    t0 = $time;
    @(posedge o_tap_events_q[0]);
    `CHK(($time - t0) / 160, 64)
    test_done;
  end
endmodule
